//--- inc/sdf_pkg.sv
`default_nettype none
// Shared constants and types for the data-frame tail and stream link
package sdf_pkg;
  // Field widths
  localparam int LEN_W = 13;
  localparam int CODE_W = 3;
  // Frame tail: zero end-of-frame bytes, then time-stamp bytes
  localparam int EOF_BYTES = 4;
  localparam int TS_BYTES = 4;
  localparam int TAIL_BYTES = EOF_BYTES + TS_BYTES;
  localparam logic [2:0] TAIL_LAST = 3'(TAIL_BYTES - 1);
  localparam logic [7:0] EOF_FILL = 8'h00;
  // Type codes
  localparam logic [2:0] TC_SUBCH = 3'h0;
  localparam logic [2:0] TC_CONTRIB = 3'h3;
  localparam logic [2:0] TC_FIG = 3'h4;
  localparam logic [2:0] TC_FIB = 3'h5;
  localparam logic [2:0] TC_INHOUSE = 3'h7;
  // Type extensions
  localparam logic [2:0] EXT_AUDIO = 3'h0;
  localparam logic [2:0] EXT_SDATA = 3'h1;
  localparam logic [2:0] EXT_PKTSUB = 3'h2;
  localparam logic [2:0] EXT_PKTCONTRIB = 3'h0;
  localparam logic [2:0] EXT_FIB_ASYNC = 3'h0;
  localparam logic [2:0] EXT_FIB_SYNC = 3'h1;
  localparam logic [2:0] EXT_FIG_LAST = 3'h2;
  // Fast information block size and per-frame limits
  localparam logic [LEN_W-1:0] FIB_BYTES = 13'h0020;
  localparam logic [LEN_W-1:0] FIB_MAX_STD = 13'h0003;
  localparam logic [LEN_W-1:0] FIB_MAX_M3 = 13'h0004;
  // Reset values
  localparam logic [LEN_W-1:0] LEN_RST = 13'h0000;
  localparam logic [31:0] TS_RST = 32'h00000000;
  localparam logic [7:0] FRAME_RST = 8'h00;

  // Link beat kinds
  typedef enum logic [1:0] {
    KIND_DESC = 2'b00,
    KIND_DATA = 2'b01,
    KIND_EOF = 2'b10,
    KIND_TS = 2'b11
  } sdf_kind_type;

  // Payload sinks on the receiving side
  typedef enum logic [3:0] {
    SINK_AUDIO = 4'h0,
    SINK_SDATA = 4'h1,
    SINK_PKTSUB = 4'h2,
    SINK_PKTCONTRIB = 4'h3,
    SINK_FIG = 4'h4,
    SINK_FIB_ASYNC = 4'h5,
    SINK_FIB_SYNC = 4'h6,
    SINK_INHOUSE = 4'h7,
    SINK_DROP = 4'h8
  } sdf_sink_type;

  // One buffered payload byte
  typedef struct packed {
    sdf_sink_type sink;
    logic first;
    logic last;
    logic [7:0] data;
  } sdf_beat_type;
endpackage
`default_nettype wire

//--- inc/sdf_link_if.sv
`default_nettype none
// Byte link from the stream sender to the stream receiver
interface sdf_link_if
  import sdf_pkg::*;
(
  input wire logic clock, // Common clock
  input wire logic nrst // Asynchronous reset, active low
);
  logic valid;
  logic ready;
  sdf_kind_type kind;
  logic [7:0] data;
  logic [CODE_W-1:0] streamTypeCode;
  logic [CODE_W-1:0] streamTypeExtension;
  logic [LEN_W-1:0] streamByteLength;

  modport sender (
    input clock, nrst, ready,
    output valid, kind, data, streamTypeCode, streamTypeExtension, streamByteLength
  );
  modport receiver (
    input clock, nrst, valid, kind, data, streamTypeCode, streamTypeExtension, streamByteLength,
    output ready
  );
endinterface
`default_nettype wire

//--- hw/sdf_sender.sv
`default_nettype none
// Upstream end: frames user streams onto the link and closes each frame with its tail
module sdf_sender
  import sdf_pkg::*;
(
  sdf_link_if.sender link, // Link to the receiver
  input wire logic clkEn, // Clock enable, freezes state when low
  input wire logic reqValid, // Stream descriptor offered
  input wire logic [CODE_W-1:0] reqTypeCode, // Stream type code
  input wire logic [CODE_W-1:0] reqTypeExtension, // Stream type extension
  input wire logic [LEN_W-1:0] reqByteLength, // Stream byte count, zero allowed
  output logic reqReady, // Descriptor taken
  output logic reqReject, // Descriptor refused, one-cycle pulse
  input wire logic inValid, // Payload byte offered
  input wire logic [7:0] inByte, // Payload byte
  output logic inReady, // Payload byte taken
  input wire logic closeValid, // Close frame request
  input wire logic [31:0] closeTimeStamp, // Time stamp for the frame tail
  output logic closeReady // Close request taken
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DESC = 2'b01,
    S_DATA = 2'b10,
    S_TAIL = 2'b11
  } sdf_tx_state_type;

  sdf_tx_state_type state_r;
  logic [LEN_W-1:0] remain_r;
  logic [2:0] tailIdx_r;
  logic [31:0] ts_r;
  logic fibSeen_r;
  logic figSeen_r;
  logic [CODE_W-1:0] figExt_r;
  logic valid_r;
  sdf_kind_type kind_r;
  logic [7:0] data_r;
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] ext_r;
  logic [LEN_W-1:0] len_r;
  logic reqReady_r;
  logic reqReject_r;
  logic inReady_r;
  logic closeReady_r;
  logic badFib;
  logic badFig;

  // Second block stream, or a changed tag on a tag-group stream, is refused
  assign badFib = (reqTypeCode == TC_FIB) && fibSeen_r;
  assign badFig = (reqTypeCode == TC_FIG) && figSeen_r && (reqTypeExtension != figExt_r);

  assign link.valid = valid_r;
  assign link.kind = kind_r;
  assign link.data = data_r;
  assign link.streamTypeCode = code_r;
  assign link.streamTypeExtension = ext_r;
  assign link.streamByteLength = len_r;
  assign reqReady = reqReady_r;
  assign reqReject = reqReject_r;
  assign inReady = inReady_r;
  assign closeReady = closeReady_r;

  // Frame sequencing and link output slot
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      state_r <= S_IDLE;
      remain_r <= LEN_RST;
      tailIdx_r <= 3'h0;
      ts_r <= TS_RST;
      valid_r <= 1'b0;
      kind_r <= KIND_DESC;
      data_r <= 8'h00;
      code_r <= 3'h0;
      ext_r <= 3'h0;
      len_r <= LEN_RST;
      reqReady_r <= 1'b0;
      reqReject_r <= 1'b0;
      inReady_r <= 1'b0;
      closeReady_r <= 1'b0;
    end else if (clkEn) begin
      reqReject_r <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          reqReady_r <= 1'b1;
          closeReady_r <= 1'b1;
          if (reqValid && reqReady_r) begin
            reqReady_r <= 1'b0;
            closeReady_r <= 1'b0;
            if (badFib || badFig) begin
              reqReject_r <= 1'b1;
            end else begin
              valid_r <= 1'b1;
              kind_r <= KIND_DESC;
              code_r <= reqTypeCode;
              ext_r <= reqTypeExtension;
              len_r <= reqByteLength;
              remain_r <= reqByteLength;
              state_r <= S_DESC;
            end
          end else if (closeValid && closeReady_r) begin
            reqReady_r <= 1'b0;
            closeReady_r <= 1'b0;
            ts_r <= closeTimeStamp;
            valid_r <= 1'b1;
            kind_r <= KIND_EOF;
            data_r <= EOF_FILL;
            tailIdx_r <= 3'h0;
            state_r <= S_TAIL;
          end
        end
        S_DESC: begin
          if (link.ready) begin
            valid_r <= 1'b0;
            // Zero length keeps the stream open with no payload
            if (remain_r == LEN_RST) begin
              state_r <= S_IDLE;
            end else begin
              inReady_r <= 1'b1;
              state_r <= S_DATA;
            end
          end
        end
        S_DATA: begin
          if (inValid && inReady_r) begin
            inReady_r <= 1'b0;
            valid_r <= 1'b1;
            kind_r <= KIND_DATA;
            data_r <= inByte;
            remain_r <= remain_r - 13'h0001;
          end else if (valid_r && link.ready) begin
            valid_r <= 1'b0;
            if (remain_r == LEN_RST) begin
              state_r <= S_IDLE;
            end else begin
              inReady_r <= 1'b1;
            end
          end
        end
        S_TAIL: begin
          if (link.ready) begin
            tailIdx_r <= tailIdx_r + 3'h1;
            if (tailIdx_r == TAIL_LAST) begin
              valid_r <= 1'b0;
              state_r <= S_IDLE;
            end else if (tailIdx_r < 3'(EOF_BYTES - 1)) begin
              data_r <= EOF_FILL;
            end else begin
              kind_r <= KIND_TS;
              data_r <= ts_r[31:24];
              ts_r <= {ts_r[23:0], 8'h00};
            end
          end
        end
      endcase
    end
  end

  // Per-frame memory of block streams; tag-group extension held until reset
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      fibSeen_r <= 1'b0;
      figSeen_r <= 1'b0;
      figExt_r <= 3'h0;
    end else if (clkEn) begin
      if (state_r == S_TAIL && link.ready && tailIdx_r == TAIL_LAST) begin
        fibSeen_r <= 1'b0;
      end else if (state_r == S_IDLE && reqValid && reqReady_r && !badFib && !badFig) begin
        if (reqTypeCode == TC_FIB) begin
          fibSeen_r <= 1'b1;
        end
        if (reqTypeCode == TC_FIG) begin
          figSeen_r <= 1'b1;
          figExt_r <= reqTypeExtension;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/sdf_receiver.sv
`default_nettype none
// Contract
// - Sender appends four zero end-of-frame bytes
// - Four time-stamp bytes follow, receiver extracts them
// - Type 0 extension 0 is audio sub-channel
// - Full-rate audio frame fits one frame
// - Half-rate audio split over two frames, reassembled
// - Type 0 extension 1 is data sub-channel
// - Type 0 extension 2 is packet sub-channel
// - Type 3 extension 0 is packet contribution
// - Tag-group stream keeps same extension each frame
// - Sender never sends configuration tag groups
// - Open tag-group stream listed, zero when empty
// - Tag groups passed through unaltered
// - Block count limited to three or four
// - Extension 0 blocks inserted when capacity spare
// - Extension 1 blocks tied to agreed frame
// - At most one block stream per frame
// - Open block stream signals zero when empty
// - In-house data forwarded without checks
// - Thirteen-bit byte length, zero is legal
module sdf_receiver
  import sdf_pkg::*;
(
  sdf_link_if.receiver link, // Link from the sender
  input wire logic clkEn, // Clock enable, freezes state when low
  input wire logic modeThree, // Allows four blocks per frame
  input wire logic halfRate, // Audio is half-rate, split over two frames
  output logic outValid, // Payload byte available
  input wire logic outReady, // Sink takes the byte
  output logic [7:0] outByte, // Payload byte
  output sdf_sink_type outSink, // Sink the byte belongs to
  output logic outFirst, // First byte of a stream or reassembled audio frame
  output logic outLast, // Last byte of a stream or reassembled audio frame
  output logic [7:0] outFrame, // Logical frame number the byte arrived in
  output logic [31:0] timeStamp, // Last extracted time stamp
  output logic timeStampValid, // New time stamp, one-cycle pulse
  output logic reservedErr, // Reserved stream type seen, one-cycle pulse
  output logic fibCountErr, // Block stream over the limit, one-cycle pulse
  output logic tailErr // Non-zero end-of-frame byte, one-cycle pulse
);
  sdf_beat_type slot_r [2];
  logic [1:0] cnt_r;
  logic [7:0] frameBuf_r [2];
  sdf_sink_type sink_r;
  logic [LEN_W-1:0] remain_r;
  logic firstPend_r;
  logic audioSecond_r;
  logic [2:0] tailIdx_r;
  logic [31:0] ts_r;
  logic tsValid_r;
  logic [7:0] frame_r;
  logic resErr_r;
  logic fibErr_r;
  logic tailErr_r;
  logic outValid_r;
  logic take;
  logic push;
  logic pop;
  sdf_sink_type descSink;
  logic [LEN_W-1:0] fibLimit;
  sdf_beat_type newBeat;
  logic isAudio;

  // Link is held off only while both buffer entries are taken
  assign link.ready = ~cnt_r[1];
  assign take = link.valid && ~cnt_r[1];
  assign push = take && (link.kind == KIND_DATA) && (sink_r != SINK_DROP);
  assign pop = cnt_r != 2'h0 && outReady;
  assign fibLimit = modeThree ? FIB_BYTES * FIB_MAX_M3 : FIB_BYTES * FIB_MAX_STD;
  assign isAudio = sink_r == SINK_AUDIO;

  // Map type code and extension of a descriptor to its sink
  always_comb begin
    descSink = SINK_DROP;
    unique case (link.streamTypeCode)
      TC_SUBCH: begin
        if (link.streamTypeExtension == EXT_AUDIO) begin
          descSink = SINK_AUDIO;
        end else if (link.streamTypeExtension == EXT_SDATA) begin
          descSink = SINK_SDATA;
        end else if (link.streamTypeExtension == EXT_PKTSUB) begin
          descSink = SINK_PKTSUB;
        end
      end
      TC_CONTRIB: begin
        if (link.streamTypeExtension == EXT_PKTCONTRIB) begin
          descSink = SINK_PKTCONTRIB;
        end
      end
      TC_FIG: begin
        if (link.streamTypeExtension <= EXT_FIG_LAST) begin
          descSink = SINK_FIG;
        end
      end
      TC_FIB: begin
        if (link.streamByteLength > fibLimit) begin
          descSink = SINK_DROP;
        end else if (link.streamTypeExtension == EXT_FIB_ASYNC) begin
          descSink = SINK_FIB_ASYNC;
        end else if (link.streamTypeExtension == EXT_FIB_SYNC) begin
          descSink = SINK_FIB_SYNC;
        end
      end
      TC_INHOUSE: begin
        descSink = SINK_INHOUSE;
      end
      default: begin
        descSink = SINK_DROP;
      end
    endcase
  end

  // Build the buffered beat; half-rate audio marks span both halves
  always_comb begin
    newBeat.sink = sink_r;
    newBeat.data = link.data;
    newBeat.first = firstPend_r && !(isAudio && halfRate && audioSecond_r);
    newBeat.last = (remain_r == 13'h0001) && !(isAudio && halfRate && !audioSecond_r);
  end

  // Stream tracking from each descriptor
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      sink_r <= SINK_DROP;
      remain_r <= LEN_RST;
      firstPend_r <= 1'b0;
      audioSecond_r <= 1'b0;
    end else if (clkEn && take) begin
      if (link.kind == KIND_DESC) begin
        sink_r <= descSink;
        remain_r <= link.streamByteLength;
        firstPend_r <= 1'b1;
      end else if (link.kind == KIND_DATA) begin
        remain_r <= remain_r - 13'h0001;
        firstPend_r <= 1'b0;
        // Half toggles once per completed audio half
        if (isAudio && halfRate && remain_r == 13'h0001) begin
          audioSecond_r <= ~audioSecond_r;
        end
      end
    end
  end

  // Frame tail: zero check, time-stamp capture, frame count
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      tailIdx_r <= 3'h0;
      ts_r <= TS_RST;
      tsValid_r <= 1'b0;
      frame_r <= FRAME_RST;
      tailErr_r <= 1'b0;
    end else if (clkEn) begin
      tsValid_r <= 1'b0;
      tailErr_r <= 1'b0;
      if (take && link.kind == KIND_EOF) begin
        tailIdx_r <= tailIdx_r + 3'h1;
        tailErr_r <= link.data != EOF_FILL;
      end else if (take && link.kind == KIND_TS) begin
        ts_r <= {ts_r[23:0], link.data};
        if (tailIdx_r == TAIL_LAST) begin
          tailIdx_r <= 3'h0;
          tsValid_r <= 1'b1;
          frame_r <= frame_r + 8'h01;
        end else begin
          tailIdx_r <= tailIdx_r + 3'h1;
        end
      end
    end
  end

  // Error pulses for refused streams
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      resErr_r <= 1'b0;
      fibErr_r <= 1'b0;
    end else if (clkEn) begin
      resErr_r <= take && link.kind == KIND_DESC && descSink == SINK_DROP &&
                  !(link.streamTypeCode == TC_FIB && link.streamByteLength > fibLimit);
      fibErr_r <= take && link.kind == KIND_DESC && link.streamTypeCode == TC_FIB &&
                  link.streamByteLength > fibLimit;
    end
  end

  // Two-entry buffer; entry 0 drives the outputs so a sink stall loses nothing
  always_ff @(posedge link.clock or negedge link.nrst) begin
    if (!link.nrst) begin
      cnt_r <= 2'h0;
      outValid_r <= 1'b0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
      frameBuf_r[0] <= FRAME_RST;
      frameBuf_r[1] <= FRAME_RST;
    end else if (clkEn) begin
      outValid_r <= cnt_r[1] || push || (cnt_r[0] && !pop);
      if (pop) begin
        slot_r[0] <= slot_r[1];
        frameBuf_r[0] <= frameBuf_r[1];
      end
      if (push) begin
        if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
          slot_r[0] <= newBeat;
          frameBuf_r[0] <= frame_r;
        end else begin
          slot_r[1] <= newBeat;
          frameBuf_r[1] <= frame_r;
        end
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

  // Outputs straight from buffer and status flops; the sink holds off
  // asynchronous blocks with outReady until the channel has room
  assign outValid = outValid_r;
  assign outByte = slot_r[0].data;
  assign outSink = slot_r[0].sink;
  assign outFirst = slot_r[0].first;
  assign outLast = slot_r[0].last;
  assign outFrame = frameBuf_r[0];
  assign timeStamp = ts_r;
  assign timeStampValid = tsValid_r;
  assign reservedErr = resErr_r;
  assign fibCountErr = fibErr_r;
  assign tailErr = tailErr_r;
endmodule
`default_nettype wire

//--- tb/sdf_link_properties.sv
`default_nettype none
// Link checks between the sender and the receiver
module sdf_link_properties
  import sdf_pkg::*;
(
  input wire logic clock, // Common clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic valid, // Beat offered
  input wire logic ready, // Receiver can take a beat
  input wire sdf_kind_type kind, // Beat kind
  input wire logic [7:0] data, // Beat byte
  input wire logic [CODE_W-1:0] streamTypeCode, // Descriptor type code
  input wire logic [CODE_W-1:0] streamTypeExtension, // Descriptor type extension
  input wire logic [LEN_W-1:0] streamByteLength // Descriptor byte count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic [2:0] tailCnt_r;
  logic [LEN_W-1:0] dataLeft_r;
  logic fibSeen_r;
  logic figSet_r;
  logic [CODE_W-1:0] figExt_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  assign take = valid && ready;

  // Position inside the frame tail, wraps after the last stamp byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tailCnt_r <= 3'h0;
    end else if (take && (kind == KIND_EOF || kind == KIND_TS)) begin
      tailCnt_r <= tailCnt_r + 3'h1;
    end
  end

  // Payload bytes still owed to the current stream
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dataLeft_r <= LEN_RST;
    end else if (take && kind == KIND_DESC) begin
      dataLeft_r <= streamByteLength;
    end else if (take && kind == KIND_DATA) begin
      dataLeft_r <= dataLeft_r - 13'h0001;
    end
  end

  // Block stream already opened in this frame
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fibSeen_r <= 1'b0;
    end else if (take && kind == KIND_DESC && streamTypeCode == TC_FIB) begin
      fibSeen_r <= 1'b1;
    end else if (take && kind == KIND_TS && tailCnt_r == TAIL_LAST) begin
      fibSeen_r <= 1'b0;
    end
  end

  // Extension of the first tag-group stream
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      figSet_r <= 1'b0;
      figExt_r <= 3'h0;
    end else if (take && kind == KIND_DESC && streamTypeCode == TC_FIG && !figSet_r) begin
      figSet_r <= 1'b1;
      figExt_r <= streamTypeExtension;
    end
  end

  chk_beat_hold: assert property (valid && !ready |=> valid &&
    $stable({kind, data, streamTypeCode, streamTypeExtension, streamByteLength}))
    else $error("beat changed while stalled");
  chk_eof_zero: assert property (valid && kind == KIND_EOF |-> data == EOF_FILL)
    else $error("end-of-frame byte not zero");
  chk_eof_count: assert property (valid && kind == KIND_EOF |-> tailCnt_r < EOF_BYTES)
    else $error("too many end-of-frame bytes");
  chk_stamp_after_eof: assert property (valid && kind == KIND_TS |-> tailCnt_r >= EOF_BYTES)
    else $error("stamp byte before end-of-frame bytes");
  chk_tail_whole: assert property (valid && kind inside {KIND_DESC, KIND_DATA} |-> tailCnt_r == 3'h0)
    else $error("frame tail cut short");
  chk_tail_flow: assert property (take && kind == KIND_EOF && tailCnt_r == 3'h3 |->
    ##[1:64] (take && kind == KIND_TS)) else $error("stamp did not follow the tail");
  chk_data_count: assert property (valid && kind == KIND_DATA |-> dataLeft_r != LEN_RST)
    else $error("more bytes than the stream length");
  chk_data_end: assert property (valid && kind != KIND_DATA |-> dataLeft_r == LEN_RST)
    else $error("stream ended before its length");
  chk_fib_once: assert property (valid && kind == KIND_DESC && streamTypeCode == TC_FIB |-> !fibSeen_r)
    else $error("second block stream in a frame");
  chk_fig_ext: assert property (valid && kind == KIND_DESC && streamTypeCode == TC_FIG && figSet_r |->
    streamTypeExtension == figExt_r) else $error("tag-group extension changed");

  // Main scenarios seen on the link
  cover property (take && kind == KIND_TS && tailCnt_r == TAIL_LAST);
  cover property (valid && !ready);
  cover property (take && kind == KIND_DESC && streamByteLength == LEN_RST);
  cover property (take && kind == KIND_DESC && streamTypeCode == TC_FIB);
endmodule
`default_nettype wire

//--- tb/sti_data_frame_tail_and_streams_tb_top.sv
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
// Both link ends joined, plus a receiver fed by a faulty driver
module sti_data_frame_tail_and_streams_tb_top
  import sdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, nrst = 1'b0, reqValid = 1'b0, inValid = 1'b0, closeValid = 1'b0, outReady = 1'b0;
  logic modeThree = 1'b0, halfRate = 1'b1, reqReady, reqReject, inReady, closeReady, outValid, outFirst, outLast;
  logic [2:0] reqTypeCode = 3'h0, reqTypeExtension = 3'h0;
  logic [LEN_W-1:0] reqByteLength = LEN_RST;
  logic [7:0] inByte = 8'h00, outByte, outFrame, fr = FRAME_RST;
  logic [31:0] closeTimeStamp = TS_RST, timeStamp, ts2;
  logic timeStampValid, reservedErr, fibCountErr, tailErr, tsV2, tailErr2;
  sdf_sink_type outSink;
  sdf_beat_type expQ[$], b;
  logic [7:0] frQ[$], f;
  logic [31:0] tsQ[$];
  int nErrors = 0, nTests = 0, nRej = 0, nRes = 0, nFib = 0, nTail2 = 0, nTs2 = 0, expRej = 0, expRes = 0, expFib = 0;
  logic [5:0] typeList[7] = '{6'h00, 6'h01, 6'h02, 6'h18, 6'h21, 6'h38, 6'h01};

  sdf_link_if link (.clock(clock), .nrst(nrst));
  sdf_link_if link2 (.clock(clock), .nrst(nrst));
  sdf_sender sdf_sender_i (.link(link.sender), .clkEn(1'b1), .reqValid(reqValid), .reqTypeCode(reqTypeCode),
    .reqTypeExtension(reqTypeExtension), .reqByteLength(reqByteLength), .reqReady(reqReady), .reqReject(reqReject),
    .inValid(inValid), .inByte(inByte), .inReady(inReady), .closeValid(closeValid),
    .closeTimeStamp(closeTimeStamp), .closeReady(closeReady));
  sdf_receiver sdf_receiver_i (.link(link.receiver), .clkEn(1'b1), .modeThree(modeThree), .halfRate(halfRate),
    .outValid(outValid), .outReady(outReady), .outByte(outByte), .outSink(outSink), .outFirst(outFirst),
    .outLast(outLast), .outFrame(outFrame), .timeStamp(timeStamp), .timeStampValid(timeStampValid),
    .reservedErr(reservedErr), .fibCountErr(fibCountErr), .tailErr(tailErr));
  sdf_receiver sdf_receiver_fault_i (.link(link2.receiver), .clkEn(1'b1), .modeThree(modeThree),
    .halfRate(halfRate), .outValid(), .outReady(1'b1), .outByte(), .outSink(), .outFirst(), .outLast(),
    .outFrame(), .timeStamp(ts2), .timeStampValid(tsV2), .reservedErr(), .fibCountErr(), .tailErr(tailErr2));
  sdf_link_properties sdf_link_properties_i (.clock(clock), .nrst(nrst), .valid(link.valid), .ready(link.ready),
    .kind(link.kind), .data(link.data), .streamTypeCode(link.streamTypeCode),
    .streamTypeExtension(link.streamTypeExtension), .streamByteLength(link.streamByteLength));

  // Clock of 4 ns
  initial begin
    forever #2 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic hi(input int s);
    case (s)
      0: return reqReady;
      1: return inReady;
      2: return closeReady;
      default: return link2.ready;
    endcase
  endfunction

  // Bounded wait for a ready sampled high at an edge
  task automatic wait_hi(input int s);
    int w;
    w = 0;
    do begin
      @(posedge clock);
      if (++w > 3000) begin
        nErrors++;
        $display("wrong value at %0t: wait ran out", $time);
        report_and_stop();
      end
    end while (hi(s) !== 1'b1);
  endtask

  function automatic sdf_sink_type sink_of(input logic [5:0] t);
    case (t)
      6'h00: return SINK_AUDIO;
      6'h01: return SINK_SDATA;
      6'h02: return SINK_PKTSUB;
      6'h18: return SINK_PKTCONTRIB;
      6'h20, 6'h21, 6'h22: return SINK_FIG;
      6'h28: return SINK_FIB_ASYNC;
      6'h29: return SINK_FIB_SYNC;
      default: return (t[5:3] == 3'h7) ? SINK_INHOUSE : SINK_DROP;
    endcase
  endfunction

  // One descriptor and its payload; notes the bytes the sink should get
  task automatic put_stream(input logic [5:0] t, input int n, input bit fo, input bit lo, input bit rej);
    sdf_beat_type e;
    @(posedge clock);
    reqTypeCode <= t[5:3];
    reqTypeExtension <= t[2:0];
    reqByteLength <= LEN_W'(n);
    reqValid <= 1'b1;
    wait_hi(0);
    reqValid <= 1'b0;
    e.sink = (t[5:3] == TC_FIB && n > 32 * (modeThree ? 4 : 3)) ? SINK_DROP : sink_of(t);
    if (rej) expRej++;
    else if (e.sink == SINK_DROP && t[5:3] == TC_FIB) expFib++;
    else if (e.sink == SINK_DROP) expRes++;
    for (int k = 0; k < n && !rej; k++) begin
      e.data = 8'($urandom);
      e.first = fo && k == 0;
      e.last = lo && k == n - 1;
      inByte <= e.data;
      inValid <= 1'b1;
      wait_hi(1);
      if (e.sink != SINK_DROP) begin
        expQ.push_back(e);
        frQ.push_back(fr);
      end
    end
    inValid <= 1'b0;
    inByte <= 8'($urandom);
  endtask

  // Closes the frame with a random stamp
  task automatic close_frame();
    logic [31:0] t;
    @(posedge clock);
    t = $urandom;
    closeTimeStamp <= t;
    closeValid <= 1'b1;
    wait_hi(2);
    closeValid <= 1'b0;
    tsQ.push_back(t);
    fr++;
  endtask

  // Faulty far end beat on the second link
  task automatic put2(input sdf_kind_type k, input logic [7:0] d);
    @(posedge clock);
    link2.kind <= k;
    link2.data <= d;
    link2.valid <= 1'b1;
    wait_hi(3);
    link2.valid <= 1'b0;
    link2.data <= ~d;
  endtask

  task automatic settle();
    int w;
    w = 0;
    while (expQ.size() != 0 || tsQ.size() != 0) begin
      @(posedge clock);
      if (++w > 3000) `CHK(w, 0)
      if (w > 3000) report_and_stop();
    end
    repeat (4) @(posedge clock);
  endtask

  // Stalls the sink at random and compares what comes out
  always @(posedge clock) begin
    outReady <= ($urandom_range(3) == 0);
    if (nrst === 1'b1) begin
      if (outValid === 1'b1 && outReady === 1'b1) begin
        b = expQ.pop_front();
        f = frQ.pop_front();
        `CHK({outSink, outFirst, outLast, outByte}, b)
        `CHK(outFrame, f)
      end
      if (timeStampValid === 1'b1) `CHK(timeStamp, tsQ.pop_front())
      if (tsV2 === 1'b1) `CHK(ts2, 32'h12345678)
      nRej += (reqReject === 1'b1);
      nRes += (reservedErr === 1'b1);
      nFib += (fibCountErr === 1'b1);
      nTail2 += (tailErr2 === 1'b1) + (tailErr !== 1'b0);
      nTs2 += (tsV2 === 1'b1);
    end
  end

  // Main sequence
  initial begin
    link2.valid = 1'b0;
    link2.kind = KIND_DESC;
    link2.data = 8'h00;
    link2.streamTypeCode = TC_SUBCH;
    link2.streamTypeExtension = EXT_SDATA;
    link2.streamByteLength = 13'h0001;
    void'($urandom(32'hca17));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    put_stream(6'h00, 5, 1, 0, 0);
    put_stream(6'h28, 0, 1, 1, 0);
    close_frame();
    put_stream(6'h00, 5, 0, 1, 0);
    close_frame();
    settle();
    halfRate <= 1'b0;
    foreach (typeList[i]) put_stream(typeList[i], $urandom_range(9), 1, 1, 0);
    put_stream(6'h28, 96, 1, 1, 0);
    put_stream(6'h29, 1, 1, 1, 1);
    close_frame();
    put_stream(6'h22, 1, 1, 1, 1);
    put_stream(6'h21, 0, 1, 1, 0);
    for (int i = 0; i < 5; i++) put_stream(6'(48'h083003101900 >> (8 * i + 8)), 2, 1, 1, 0);
    put_stream(6'h29, 97, 1, 1, 0);
    close_frame();
    settle();
    modeThree <= 1'b1;
    put_stream(6'h29, 128, 1, 1, 0);
    put_stream(6'h3f, 3, 1, 1, 0);
    close_frame();
    settle();
    put2(KIND_DESC, 8'h00);
    put2(KIND_DATA, 8'h5a);
    for (int i = 0; i < 4; i++) put2(KIND_EOF, (i == 1) ? 8'h01 : 8'h00);
    for (int i = 0; i < 4; i++) put2(KIND_TS, 8'(32'h12345678 >> (24 - 8 * i)));
    settle();
    `CHK(nRej, expRej)
    `CHK(nRes, expRes)
    `CHK(nFib, expFib)
    `CHK(nTail2, 1)
    `CHK(nTs2, 1)
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
